// ### design/sfifo_top.sv
/*
   Sample FIFO of a three-axis acceleration sensor: stores up to 32 samples,
   offers disabled, circular, fill and trigger modes, keeps overflow and
   watermark flags, the sample count and a FIFO interrupt source bit.
   Assumes a serial register slave on core_clk that turns each byte access
   into one regRdStrobe or regWrStrobe pulse with its address, advancing the
   address itself; sample, trigger and mode-change pulses come from logic
   on core_clk, so none of them is synchronised here.
*/
//
// Function
// - status at 0x00 when FIFO mode nonzero
// - status: overflow bit7, watermark bit6, count 5:0
// - count gives stored samples, zero means empty
// - overflow set at count 32, held meanwhile
// - watermark set while count reaches nonzero level
// - watermark level zero suppresses watermark flag
// - status read clears interrupt; next flagged sample sets
// - modes: off, circular overwrite, fill stops full
// - trigger: circular, then 32 minus level more
// - in trigger mode watermark flag means triggered
// - trigger overflow zero before trigger, then stopped
// - flush on disable, rate change, standby exit
// - writing disabled mode zeroes flags and count
// - count above level never stops acceptance
// - samples arrive at the selected output rate
// - data read returns oldest, count drops one
// - setup at 0x09: mode 7:6, level 5:0
// - in trigger mode level sets pre-trigger depth
// - data from 0x01, fast read skips low bytes
`timescale 1ns/10ps
`default_nettype none

module sfifo_top #(
   parameter int DEPTH = 32,
   parameter int SAMPLE_W = 14
)(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [7:0] regAddr,
   input wire logic regRdStrobe,
   input wire logic regWrStrobe,
   input wire logic [7:0] regWrData,
   input wire logic [7:0] realTimeStatus,
   input wire logic fastRead,
   input wire logic sampleStrobe,
   input wire logic [SAMPLE_W-1:0] sampleX,
   input wire logic [SAMPLE_W-1:0] sampleY,
   input wire logic [SAMPLE_W-1:0] sampleZ,
   input wire logic triggerEvent,
   input wire logic rateChange,
   input wire logic standbyToActive,
   output logic [7:0] regRdData,
   output logic fifoOn,
   output logic fifoIrqPending
);

   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = PTR_W + 1;
   localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
   localparam int SMP_W = 3 * SAMPLE_W;

   ////////////////////////////////////////////////////////////////////////
   // declarations

   logic [1:0] mode_r;
   logic [5:0] wmrkLevel_r;
   logic fifoOn_r;
   logic [SMP_W-1:0] store [DEPTH];
   logic [PTR_W-1:0] wrPtr_r;
   logic [PTR_W-1:0] rdPtr_r;
   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] count_nxt;
   logic [CNT_W-1:0] postLeft_r;
   sfifo_pkg::sfifo_trig_t trig_r;
   sfifo_pkg::sfifo_trig_t trig_nxt;
   logic overflowFlag_r;
   logic overflowFlag_nxt;
   logic watermarkHit_r;
   logic watermarkHit_nxt;
   logic irqPending_r;
   logic [SMP_W-1:0] held_r;
   logic heldStale_r;
   logic [7:0] regRdData_r;
   logic [7:0] rdByte;
   logic [SMP_W-1:0] headSample;
   logic [SMP_W-1:0] byteSource;
   logic [SAMPLE_W-1:0] axisWord;
   logic full;
   logic levelOn;
   logic atLevel;
   logic writeOff;
   logic flush;
   logic accept;
   logic push;
   logic drop;
   logic pop;
   logic dataRead;
   logic startRead;
   logic lastRead;
   logic statusRead;

   ////////////////////////////////////////////////////////////////////////
   // setup register

   // mode may change any time; host keeps the off-first ordering
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         mode_r <= sfifo_pkg::SETUP_RESET[sfifo_pkg::MODE_HI:sfifo_pkg::MODE_LO];
         wmrkLevel_r <= sfifo_pkg::SETUP_RESET[sfifo_pkg::LEVEL_HI:0];
         fifoOn_r <= 1'b0;
      end
      else if (regWrStrobe && regAddr == sfifo_pkg::ADDR_SETUP)
      begin
         mode_r <= regWrData[sfifo_pkg::MODE_HI:sfifo_pkg::MODE_LO];
         wmrkLevel_r <= regWrData[sfifo_pkg::LEVEL_HI:0];
         fifoOn_r <= regWrData[sfifo_pkg::MODE_HI:sfifo_pkg::MODE_LO] != sfifo_pkg::MODE_OFF;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // push, drop and pop decisions

   // strobes and flush conditions
   always_comb
   begin
      full = count_r == FULL_COUNT;
      levelOn = wmrkLevel_r != 6'h00;
      atLevel = levelOn && CNT_W'(wmrkLevel_r) <= count_r;
      writeOff = regWrStrobe && regAddr == sfifo_pkg::ADDR_SETUP
         && regWrData[sfifo_pkg::MODE_HI:sfifo_pkg::MODE_LO] == sfifo_pkg::MODE_OFF;
      flush = !fifoOn_r || writeOff || rateChange || standbyToActive;
      statusRead = regRdStrobe && regAddr == sfifo_pkg::ADDR_STATUS && fifoOn_r;
      dataRead = regRdStrobe && fifoOn_r
         && regAddr >= sfifo_pkg::ADDR_X_MSB && regAddr <= sfifo_pkg::ADDR_Z_LSB;
      startRead = dataRead && regAddr == sfifo_pkg::ADDR_X_MSB;
      lastRead = dataRead && regAddr == (fastRead ? sfifo_pkg::ADDR_Z_MSB
         : sfifo_pkg::ADDR_Z_LSB);
   end

   // acceptance per mode; a count past the level never blocks
   always_comb
   begin
      case (mode_r)
         sfifo_pkg::MODE_CIRC: accept = 1'b1;
         sfifo_pkg::MODE_FILL: accept = !full;
         sfifo_pkg::MODE_TRIG: accept = trig_r == sfifo_pkg::TRIG_ARMED
            || (trig_r == sfifo_pkg::TRIG_POST && !full);
         default: accept = 1'b0;
      endcase
      push = sampleStrobe && !flush && accept;
      pop = lastRead && !heldStale_r && count_r != '0 && !flush;
      // pre-trigger keeps only the level's worth of history
      drop = push && !pop && count_r != '0
         && ((mode_r == sfifo_pkg::MODE_CIRC && full)
         || (mode_r == sfifo_pkg::MODE_TRIG && trig_r == sfifo_pkg::TRIG_ARMED
         && (full || atLevel)));
      if (flush)
         count_nxt = '0;
      else if (push && !pop && !drop)
         count_nxt = count_r + CNT_W'(1);
      else if (pop && !push)
         count_nxt = count_r - CNT_W'(1);
      else
         count_nxt = count_r;
   end

   ////////////////////////////////////////////////////////////////////////
   // storage and pointers

   // array is left unreset: its contents mean nothing until counted
   always_ff @(posedge core_clk)
   begin
      if (push)
         store[wrPtr_r] <= {sampleX, sampleY, sampleZ};
   end

   // pointers and count
   always_ff @(posedge core_clk)
   begin
      if (sys_rst || flush)
      begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end
      else
      begin
         if (push)
            wrPtr_r <= wrPtr_r + PTR_W'(1);
         if (pop || drop)
            rdPtr_r <= rdPtr_r + PTR_W'(1);
         count_r <= count_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // trigger capture

   // next trigger state; a sample in the trigger cycle counts as history
   always_comb
   begin
      trig_nxt = trig_r;
      case (trig_r)
         sfifo_pkg::TRIG_ARMED:
            if (mode_r == sfifo_pkg::MODE_TRIG && triggerEvent)
               trig_nxt = ({1'b0, wmrkLevel_r} >= 7'(DEPTH)) ? sfifo_pkg::TRIG_DONE
                  : sfifo_pkg::TRIG_POST;
         sfifo_pkg::TRIG_POST:
            if ((push && postLeft_r == CNT_W'(1)) || (sampleStrobe && full))
               trig_nxt = sfifo_pkg::TRIG_DONE;
         sfifo_pkg::TRIG_DONE: trig_nxt = sfifo_pkg::TRIG_DONE;
         default: trig_nxt = sfifo_pkg::TRIG_ARMED;
      endcase
      if (flush || mode_r != sfifo_pkg::MODE_TRIG)
         trig_nxt = sfifo_pkg::TRIG_ARMED;
   end

   // trigger state and remaining post-trigger samples
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         trig_r <= sfifo_pkg::TRIG_ARMED;
         postLeft_r <= '0;
      end
      else
      begin
         trig_r <= trig_nxt;
         if (trig_r == sfifo_pkg::TRIG_ARMED)
            postLeft_r <= FULL_COUNT - CNT_W'(wmrkLevel_r);
         else if (push)
            postLeft_r <= postLeft_r - CNT_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flags and interrupt source

   // flags follow the next count so they line up with it
   always_comb
   begin
      if (flush)
      begin
         overflowFlag_nxt = 1'b0;
         watermarkHit_nxt = 1'b0;
      end
      else if (mode_r == sfifo_pkg::MODE_TRIG)
      begin
         overflowFlag_nxt = trig_nxt == sfifo_pkg::TRIG_DONE;
         watermarkHit_nxt = trig_nxt != sfifo_pkg::TRIG_ARMED;
      end
      else
      begin
         overflowFlag_nxt = count_nxt == FULL_COUNT;
         watermarkHit_nxt = levelOn
            && CNT_W'(wmrkLevel_r) <= count_nxt;
      end
   end

   // registered flags
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         overflowFlag_r <= 1'b0;
         watermarkHit_r <= 1'b0;
      end
      else
      begin
         overflowFlag_r <= overflowFlag_nxt;
         watermarkHit_r <= watermarkHit_nxt;
      end
   end

   // a flag-raising sample entering in the clearing cycle wins over the clear
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         irqPending_r <= 1'b0;
      else if (push && (overflowFlag_nxt || watermarkHit_nxt))
         irqPending_r <= 1'b1;
      else if (statusRead)
         irqPending_r <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // read path

   // the head is frozen at the first byte so all bytes share one sample
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         held_r <= '0;
         heldStale_r <= 1'b1;
      end
      else if (startRead)
      begin
         held_r <= headSample;
         heldStale_r <= count_r == '0 || flush;
      end
      else if (drop || flush)
         heldStale_r <= 1'b1; // head moved under us, so no retire
   end

   // byte mux: msb holds bits 13:6, lsb bits 5:0 shifted up two
   always_comb
   begin
      headSample = (count_r == '0) ? '0 : store[rdPtr_r];
      byteSource = startRead ? headSample : held_r;
      case (regAddr)
         sfifo_pkg::ADDR_X_MSB, sfifo_pkg::ADDR_X_LSB:
            axisWord = byteSource[SMP_W-1 -: SAMPLE_W];
         sfifo_pkg::ADDR_Y_MSB, sfifo_pkg::ADDR_Y_LSB:
            axisWord = byteSource[2*SAMPLE_W-1 -: SAMPLE_W];
         default: axisWord = byteSource[SAMPLE_W-1:0];
      endcase
      rdByte = 8'h00;
      if (regAddr == sfifo_pkg::ADDR_STATUS)
         rdByte = fifoOn_r ? {overflowFlag_r, watermarkHit_r, 6'(count_r)}
            : realTimeStatus;
      else if (regAddr == sfifo_pkg::ADDR_SETUP)
         rdByte = {mode_r, wmrkLevel_r};
      else if (dataRead && regAddr[0])
         rdByte = axisWord[SAMPLE_W-1 -: 8];
      else if (dataRead)
         rdByte = {axisWord[SAMPLE_W-9:0], 2'h0};
   end

   // read data register, one cycle after the strobe
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         regRdData_r <= sfifo_pkg::RDATA_RESET;
      else if (regRdStrobe)
         regRdData_r <= rdByte;
   end

   assign regRdData = regRdData_r;
   assign fifoOn = fifoOn_r;
   assign fifoIrqPending = irqPending_r;

   ////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   property p_status_layout;
      statusRead |=> regRdData == {$past(overflowFlag_r), $past(watermarkHit_r),
         6'($past(count_r))};
   endproperty
   a_status_layout: assert property (p_status_layout) else $error("status byte wrong");

   property p_count_bound;
      count_r <= FULL_COUNT;
   endproperty
   a_count_bound: assert property (p_count_bound) else $error("count above depth");

   property p_overflow_full;
      (mode_r != sfifo_pkg::MODE_TRIG && mode_r == $past(mode_r) && fifoOn_r)
         |-> overflowFlag_r == (count_r == FULL_COUNT);
   endproperty
   a_overflow_full: assert property (p_overflow_full) else $error("overflow flag mismatch");

   property p_watermark_level;
      (mode_r != sfifo_pkg::MODE_TRIG && fifoOn_r && $stable(mode_r) && $stable(wmrkLevel_r))
         |-> watermarkHit_r == (levelOn && 6'(count_r) >= wmrkLevel_r);
   endproperty
   a_watermark_level: assert property (p_watermark_level) else $error("watermark mismatch");

   property p_status_clears_irq;
      (statusRead && !push) |=> !fifoIrqPending;
   endproperty
   a_status_clears_irq: assert property (p_status_clears_irq) else $error("irq not cleared");

   property p_disable_zeroes;
      writeOff |=> (count_r == '0 && !overflowFlag_r && !watermarkHit_r) [*2];
   endproperty
   a_disable_zeroes: assert property (p_disable_zeroes) else $error("disable left state");

   property p_flush_events;
      (rateChange || standbyToActive) |=> count_r == '0;
   endproperty
   a_flush_events: assert property (p_flush_events) else $error("flush missed");

   property p_circ_keeps_full;
      (mode_r == sfifo_pkg::MODE_CIRC && full && push && !pop && !flush) |=> full ##0 $changed(rdPtr_r);
   endproperty
   a_circ_keeps_full: assert property (p_circ_keeps_full) else $error("circular wrap wrong");

   property p_trig_no_early_ovf;
      (mode_r == sfifo_pkg::MODE_TRIG && $stable(mode_r) && trig_r == sfifo_pkg::TRIG_ARMED)
         |-> !overflowFlag_r && !watermarkHit_r;
   endproperty
   a_trig_no_early_ovf: assert property (p_trig_no_early_ovf) else $error("early trig flag");

   property p_trig_stops;
      (trig_r == sfifo_pkg::TRIG_DONE && mode_r == sfifo_pkg::MODE_TRIG) |-> !push;
   endproperty
   a_trig_stops: assert property (p_trig_stops) else $error("sample after stop");

   property p_pop_decrements;
      (pop && !push) |=> count_r == $past(count_r) - CNT_W'(1);
   endproperty
   a_pop_decrements: assert property (p_pop_decrements) else $error("pop count wrong");

   property p_no_early_retire;
      (startRead && !flush) |=> count_r >= $past(count_r) || $past(flush);
   endproperty
   a_no_early_retire: assert property (p_no_early_retire) else $error("retired too early");

   c_circ_wrap: cover property (mode_r == sfifo_pkg::MODE_CIRC && drop);
   c_trig_done: cover property (trig_r == sfifo_pkg::TRIG_POST ##1 trig_r == sfifo_pkg::TRIG_DONE);
   c_fill_full: cover property (mode_r == sfifo_pkg::MODE_FILL && full && sampleStrobe);
   c_burst_retire: cover property (startRead ##[1:12] pop);

endmodule

`default_nettype wire

// ### design/sfifo_pkg.sv
/*
   Constants for the 32-entry acceleration sample FIFO: register offsets,
   field positions, reset values, mode encodings and the trigger state type.
   Assumes nothing of its surroundings; every user names items with sfifo_pkg::.
*/
`default_nettype none

package sfifo_pkg;

   // register byte addresses as seen by the serial register port
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_X_MSB = 8'h01;
   localparam logic [7:0] ADDR_X_LSB = 8'h02;
   localparam logic [7:0] ADDR_Y_MSB = 8'h03;
   localparam logic [7:0] ADDR_Y_LSB = 8'h04;
   localparam logic [7:0] ADDR_Z_MSB = 8'h05;
   localparam logic [7:0] ADDR_Z_LSB = 8'h06;
   localparam logic [7:0] ADDR_SETUP = 8'h09;

   // field positions in the status and setup bytes
   localparam int OVF_BIT = 7;
   localparam int WMRK_BIT = 6;
   localparam int MODE_HI = 7;
   localparam int MODE_LO = 6;
   localparam int LEVEL_HI = 5;

   // values after reset
   localparam logic [7:0] SETUP_RESET = 8'h00;
   localparam logic [7:0] RDATA_RESET = 8'h00;

   // mode selection encodings
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_CIRC = 2'h1;
   localparam logic [1:0] MODE_FILL = 2'h2;
   localparam logic [1:0] MODE_TRIG = 2'h3;

   // trigger capture progress
   typedef enum logic [1:0] {TRIG_ARMED, TRIG_POST, TRIG_DONE} sfifo_trig_t;

endpackage

`default_nettype wire

// ### bench/sfifo_host_model.sv
/*
   Host processor model: single byte writes and reads on the register port.
   Assumes the slave takes a strobe at a rising edge and answers one cycle later.
*/
`timescale 1ns/10ps
`default_nettype none

module sfifo_host_model (
   input wire logic coreClk,
   input wire logic [7:0] regRdData,
   output logic [7:0] regAddr,
   output logic regRdStrobe,
   output logic regWrStrobe,
   output logic [7:0] regWrData
);
   // idle address is inverted after each access, write data after each write, so nothing stale is seen
   initial
   begin
      regAddr = 8'h00;
      regRdStrobe = 1'b0;
      regWrStrobe = 1'b0;
      regWrData = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // write: mode changes always go through 00 first, done by the caller
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge coreClk);
      regAddr = a;
      regWrData = d;
      regWrStrobe = 1'b1;
      @(negedge coreClk);
      regWrStrobe = 1'b0;
      regAddr = ~a;
      regWrData = ~d;
   endtask

   // read: byte is settled one falling edge after the strobe was taken
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge coreClk);
      regAddr = a;
      regRdStrobe = 1'b1;
      @(negedge coreClk);
      regRdStrobe = 1'b0;
      regAddr = ~a;
      d = regRdData;
   endtask
endmodule

`default_nettype wire

// ### bench/test_sample_fifo_32.sv
/*
   Self-checking bench for the sample FIFO: table of mode cases, then data,
   flush, interrupt and register checks. Assumes the host model file.
*/
`timescale 1ns/10ps
`default_nettype none

module test_sample_fifo_32;
   typedef struct packed {
      logic [7:0] setup;
      logic [7:0] pre;
      logic trig;
      logic [7:0] post;
      logic [7:0] status;
   } sfifo_row_t;

   logic coreClk = 1'b0;
   logic sysRst = 1'b1;
   logic fastRead = 1'b0;
   logic sampleStrobe = 1'b0;
   logic [13:0] sampleX = 14'h0000;
   logic [13:0] sampleY = 14'h0000;
   logic [13:0] sampleZ = 14'h0000;
   logic [13:0] seqNo = 14'h0123;
   logic triggerEvent = 1'b0;
   logic rateChange = 1'b0;
   logic standbyToActive = 1'b0;
   logic [7:0] regAddr, regWrData, regRdData, rdByte;
   logic regRdStrobe, regWrStrobe, fifoOn, fifoIrqPending;
   logic [13:0] s;
   int numErrors = 0;
   int testsRun = 0;
   sfifo_row_t rows [10] = '{
      '{8'h00, 8'd3, 1'b0, 8'd0, 8'h5a}, '{8'h40, 8'd5, 1'b0, 8'd0, 8'h05},
      '{8'h44, 8'd3, 1'b0, 8'd0, 8'h03}, '{8'h44, 8'd4, 1'b0, 8'd0, 8'h44},
      '{8'h44, 8'd40, 1'b0, 8'd0, 8'he0}, '{8'h80, 8'd40, 1'b0, 8'd0, 8'ha0},
      '{8'h9f, 8'd33, 1'b0, 8'd0, 8'he0}, '{8'hc8, 8'd20, 1'b0, 8'd0, 8'h08},
      '{8'hc8, 8'd20, 1'b1, 8'd10, 8'h52}, '{8'hc8, 8'd3, 1'b1, 8'd40, 8'hdb}};

   // 40 MHz clock
   always #12.5 coreClk = ~coreClk;

   sfifo_host_model host (.coreClk(coreClk), .regRdData(regRdData), .regAddr(regAddr),
      .regRdStrobe(regRdStrobe), .regWrStrobe(regWrStrobe), .regWrData(regWrData));

   sfifo_top dut (.core_clk(coreClk), .sys_rst(sysRst), .regAddr(regAddr),
      .regRdStrobe(regRdStrobe), .regWrStrobe(regWrStrobe), .regWrData(regWrData),
      .realTimeStatus(8'h5a), .fastRead(fastRead), .sampleStrobe(sampleStrobe),
      .sampleX(sampleX), .sampleY(sampleY), .sampleZ(sampleZ),
      .triggerEvent(triggerEvent), .rateChange(rateChange),
      .standbyToActive(standbyToActive), .regRdData(regRdData), .fifoOn(fifoOn),
      .fifoIrqPending(fifoIrqPending));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      testsRun++;
      if (seen !== exp)
      begin
         numErrors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // back-to-back samples; each axis differs so swapped bytes show up
   task automatic push(input int n);
      if (n > 0)
      begin
         @(negedge coreClk);
         sampleStrobe = 1'b1;
         repeat (n)
         begin
            sampleX = seqNo;
            sampleY = ~seqNo;
            sampleZ = seqNo ^ 14'h2aaa;
            seqNo = seqNo + 14'h0001;
            @(negedge coreClk);
         end
         sampleStrobe = 1'b0;
      end
   endtask

   function automatic logic [7:0] sampleByte(input logic [13:0] v0, input int idx);
      logic [13:0] v;
      v = (idx < 3) ? v0 : (idx < 5) ? ~v0 : (v0 ^ 14'h2aaa);
      return idx[0] ? v[13:6] : {v[5:0], 2'b00};
   endfunction

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", testsRun, numErrors);
      if (numErrors == 0 && testsRun > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // watchdog: the whole run needs a few hundred cycles
   initial
   begin
      repeat (20000) @(posedge coreClk);
      numErrors++;
      report_and_stop;
   end

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (2) @(negedge coreClk);
      sysRst = 1'b0;
      chk({7'h00, fifoOn}, 8'h00);
      chk({7'h00, fifoIrqPending}, 8'h00);
      host.rd(8'h09, rdByte);
      chk(rdByte, 8'h00);
      // mode table; a pass through 00 flushes before each row
      foreach (rows[i])
      begin
         host.wr(8'h09, 8'h00);
         host.wr(8'h09, rows[i].setup);
         chk({7'h00, fifoOn}, {7'h00, rows[i].setup[7:6] != 2'h0});
         push(rows[i].pre);
         if (rows[i].trig)
         begin
            @(negedge coreClk);
            triggerEvent = 1'b1;
            @(negedge coreClk);
            triggerEvent = 1'b0;
         end
         push(rows[i].post);
         chk({7'h00, fifoIrqPending}, {7'h00, fifoOn && rows[i].status[7:6] != 2'h0});
         host.rd(8'h00, rdByte);
         chk(rdByte, rows[i].status);
      end
      // oldest first, whole sample retired after its last byte, fast read skips lows
      host.wr(8'h09, 8'h00);
      host.wr(8'h09, 8'h40);
      s = seqNo;
      push(2);
      for (int a = 1; a <= 6; a++)
      begin
         host.rd(a[7:0], rdByte);
         chk(rdByte, sampleByte(s, a));
      end
      host.rd(8'h00, rdByte);
      chk(rdByte, 8'h01);
      fastRead = 1'b1;
      for (int a = 1; a <= 5; a += 2)
      begin
         host.rd(a[7:0], rdByte);
         chk(rdByte, sampleByte(s + 14'h0001, a));
      end
      fastRead = 1'b0;
      host.rd(8'h00, rdByte);
      chk(rdByte, 8'h00);
      host.rd(8'h01, rdByte);
      chk(rdByte, 8'h00);
      // flush on rate change and on standby exit
      push(3);
      @(negedge coreClk);
      rateChange = 1'b1;
      @(negedge coreClk);
      rateChange = 1'b0;
      host.rd(8'h00, rdByte);
      chk(rdByte, 8'h00);
      push(3);
      @(negedge coreClk);
      standbyToActive = 1'b1;
      @(negedge coreClk);
      standbyToActive = 1'b0;
      host.rd(8'h00, rdByte);
      chk(rdByte, 8'h00);
      // status read clears the pending bit; next flagging sample sets it again
      host.wr(8'h09, 8'h00);
      host.wr(8'h09, 8'h42);
      push(2);
      host.rd(8'h00, rdByte);
      chk(rdByte, 8'h42);
      @(negedge coreClk);
      chk({7'h00, fifoIrqPending}, 8'h00);
      push(1);
      chk({7'h00, fifoIrqPending}, 8'h01);
      // unmapped write ignored, unmapped read gives zero
      host.wr(8'h07, 8'hff);
      host.rd(8'h09, rdByte);
      chk(rdByte, 8'h42);
      host.rd(8'h07, rdByte);
      chk(rdByte, 8'h00);
      host.wr(8'h09, 8'h00);
      // reset in mid-run with samples stored and the interrupt pending
      host.wr(8'h09, 8'h44);
      push(5);
      chk({7'h00, fifoIrqPending}, 8'h01);
      sysRst = 1'b1;
      repeat (2) @(negedge coreClk);
      sysRst = 1'b0;
      chk(regRdData, 8'h00);
      chk({7'h00, fifoOn}, 8'h00);
      chk({7'h00, fifoIrqPending}, 8'h00);
      host.rd(8'h09, rdByte);
      chk(rdByte, 8'h00);
      host.rd(8'h00, rdByte);
      chk(rdByte, 8'h5a);
      report_and_stop;
   end
endmodule

`default_nettype wire
